// file: design/utx_pkg.sv
// Purpose: shared constants and types of the asynchronous serial transmitter
// Assumes: 32-bit Avalon-MM register window, byte addresses, one word per register
// Notes:   all registers are eight bits wide and sit in byte lane 0
package utx_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam int         ADDR_W           = 5;
   localparam logic [4:0] OFS_TX_STAT_CTRL = 5'h00;
   localparam logic [4:0] OFS_PORT_CTRL    = 5'h04;
   localparam logic [4:0] OFS_TX_HOLD      = 5'h08;
   localparam logic [4:0] OFS_BAUD_DIV     = 5'h0c;
   localparam logic [4:0] OFS_TX_FLAGS     = 5'h10;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int BIT_NINE_SEL   = 6;
   localparam int BIT_TX_EN      = 5;
   localparam int BIT_SYNC_SEL   = 4;
   localparam int BIT_SR_EMPTY   = 1;
   localparam int BIT_NINTH_VAL  = 0;
   localparam int BIT_PORT_EN    = 7;
   localparam int BIT_BUF_EMPTY  = 0;
   localparam int BIT_BUF_IRQ_EN = 1;

   // ----------------------------------------------------------------
   // reset values and timing
   // ----------------------------------------------------------------
   localparam logic [7:0]  RST_BAUD_DIV    = 8'h00;
   localparam logic [7:0]  RST_HOLD        = 8'h00;
   localparam logic [5:0]  PRESCALE_LAST   = 6'h3f;
   localparam logic [2:0]  DATA_LAST       = 3'h7;
   localparam logic [31:0] RDATA_UNMAPPED  = 32'h0000_0000;

   // register select decoded from the bus address
   typedef enum logic [2:0] {
      UTX_SEL_NONE  = 3'h0,
      UTX_SEL_STAT  = 3'h1,
      UTX_SEL_PORT  = 3'h2,
      UTX_SEL_HOLD  = 3'h3,
      UTX_SEL_BAUD  = 3'h4,
      UTX_SEL_FLAGS = 3'h5
   } utx_sel_t;

   // gray codes along idle -> loaded -> start -> data -> ninth -> stop
   typedef enum logic [2:0] {
      UTX_IDLE   = 3'b000,
      UTX_LOADED = 3'b001,
      UTX_START  = 3'b011,
      UTX_DATA   = 3'b010,
      UTX_NINTH  = 3'b110,
      UTX_STOP   = 3'b111
   } utx_state_t;

endpackage : utx_pkg

// file: design/utx_async_tx.sv
// Purpose: asynchronous-mode serial transmitter with baud generator and registers
// Assumes: ref_clk is the device oscillator; sleep_req comes from logic on ref_clk
// Notes:   receiver and synchronous mode are not part of this block
//
// Function
// RULE1: NRZ frame, one start, 8/9 data, one stop
// RULE2: baud generator with 8-bit divisor register
// RULE3: transmit independent, shares format and rate
// RULE4: baud generator ticks at 64x bit rate
// RULE5: no parity; ninth bit carries software parity
// RULE6: all async operation halts during sleep
// RULE7: async selected when sync select bit 4 clear
// RULE8: shift reg reloads only after stop bit
// RULE9: transfer at baud cycle end sets empty flag
// RULE10: empty flag set regardless of irq enable
// RULE11: flag cleared only by holding buffer write
// RULE12: bit 1 shows shift register empty, polled
// RULE13: shift register not software addressable
// RULE14: tx enable bit 5; shift needs data, tick
// RULE15: data first then enable also starts frame
// RULE16: write to empty shifter transfers at once
// RULE17: clearing tx enable aborts, pin released
// RULE18: nine-bit select bit 6, value bit 0
// RULE19: software writes ninth bit before data
// RULE20: software follows the documented setup order
// RULE21: clearing port or tx enable resets transmitter
// RULE22: rate is clock over 64 times divisor+1
// RULE23: divisor write clears the baud timer
// RULE24: reset clears divisor register to zero
// RULE25: data sent lsb first, ninth bit last
// RULE26: idle line high, start low, stop high
`timescale 1ns/1ps
`default_nettype none

module utx_async_tx
   import utx_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input  wire logic              ref_clk,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   input  wire logic [3:0]        avs_byteenable,
   output var  logic [31:0]       avs_readdata,
   output var  logic              avs_waitrequest,
   input  wire logic              sleep_req,
   output var  logic              tx_pin_o,
   output var  logic              tx_pin_oe,
   output var  logic              tx_irq_req
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   if (DIV_W != 8) begin : g_bad_div_w
      $error("utx_async_tx: divisor width must be 8");
   end

   // the register map must decode on exactly the bus address bits
   if ($bits(OFS_TX_FLAGS) != ADDR_W) begin : g_bad_addr_w
      $error("utx_async_tx: register offsets must match the address width");
   end

   // the x64 rate relies on the prescaler wrapping through all its states
   if (PRESCALE_LAST != '1) begin : g_bad_prescale
      $error("utx_async_tx: prescaler must count through all of its states");
   end

   // a frame always carries eight data bits before the optional ninth
   if (DATA_LAST != '1) begin : g_bad_data_last
      $error("utx_async_tx: bit counter must cover eight data bits");
   end

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic utx_sel_t reg_sel(input logic [ADDR_W-1:0] addr);
      case (addr)
         OFS_TX_STAT_CTRL: reg_sel = UTX_SEL_STAT;
         OFS_PORT_CTRL:    reg_sel = UTX_SEL_PORT;
         OFS_TX_HOLD:      reg_sel = UTX_SEL_HOLD;
         OFS_BAUD_DIV:     reg_sel = UTX_SEL_BAUD;
         OFS_TX_FLAGS:     reg_sel = UTX_SEL_FLAGS;
         default:          reg_sel = UTX_SEL_NONE;
      endcase
   endfunction : reg_sel

   logic             wait_q;
   logic [31:0]      rdata_q;
   logic             nine_sel_q;
   logic             tx_en_q;
   logic             sync_sel_q;
   logic             ninth_val_q;
   logic             port_en_q;
   logic             irq_en_q;
   logic [DIV_W-1:0] baud_div_q;
   logic [7:0]       hold_q;
   logic             hold_full_q;
   logic [DIV_W-1:0] div_cnt_q;
   logic [5:0]       pre_cnt_q;
   logic             bit_tick;
   logic [8:0]       shift_q;
   logic [2:0]       bit_cnt_q;
   utx_state_t       state_q;
   utx_state_t       state_d;
   logic             line_d;
   logic             data_bit;
   logic             tx_line_q;
   logic             oe_q;
   logic             irq_q;
   logic             wr_acc;
   logic             wr_lane0;
   utx_sel_t         wsel;
   logic             tx_active;
   logic             run;
   logic             transfer;

   // ----------------------------------------------------------------
   // avalon slave: waitrequest drops for one cycle per request
   // ----------------------------------------------------------------
   // a write takes effect at the edge where the master sees waitrequest low
   assign wr_acc   = avs_write && !wait_q;
   assign wr_lane0 = wr_acc && avs_byteenable[0];
   assign wsel     = reg_sel(avs_address);

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wait_q <= 1'b1;
      end else if (wait_q && (avs_read || avs_write)) begin
         wait_q <= 1'b0;
      end else begin
         wait_q <= 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_q <= RDATA_UNMAPPED;
      end else if (wait_q && avs_read) begin
         rdata_q <= RDATA_UNMAPPED;
         case (reg_sel(avs_address))
            UTX_SEL_STAT: begin
               rdata_q[BIT_NINE_SEL]  <= nine_sel_q;
               rdata_q[BIT_TX_EN]     <= tx_en_q;
               rdata_q[BIT_SYNC_SEL]  <= sync_sel_q;
               rdata_q[BIT_SR_EMPTY]  <= (state_q == UTX_IDLE);     // RULE12
               rdata_q[BIT_NINTH_VAL] <= ninth_val_q;
            end
            UTX_SEL_PORT:  rdata_q[BIT_PORT_EN] <= port_en_q;
            UTX_SEL_HOLD:  rdata_q[7:0] <= hold_q;                  // RULE13
            UTX_SEL_BAUD:  rdata_q[DIV_W-1:0] <= baud_div_q;
            UTX_SEL_FLAGS: begin
               rdata_q[BIT_BUF_EMPTY]  <= !hold_full_q;
               rdata_q[BIT_BUF_IRQ_EN] <= irq_en_q;
            end
            default:       rdata_q <= RDATA_UNMAPPED;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         nine_sel_q  <= 1'b0;
         tx_en_q     <= 1'b0;
         sync_sel_q  <= 1'b0;
         ninth_val_q <= 1'b0;
      end else if (wr_lane0 && wsel == UTX_SEL_STAT) begin
         nine_sel_q  <= avs_writedata[BIT_NINE_SEL];                // RULE18
         tx_en_q     <= avs_writedata[BIT_TX_EN];                   // RULE14
         sync_sel_q  <= avs_writedata[BIT_SYNC_SEL];
         ninth_val_q <= avs_writedata[BIT_NINTH_VAL];               // RULE5
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         port_en_q <= 1'b0;
      end else if (wr_lane0 && wsel == UTX_SEL_PORT) begin
         port_en_q <= avs_writedata[BIT_PORT_EN];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_en_q <= 1'b0;
      end else if (wr_lane0 && wsel == UTX_SEL_FLAGS) begin
         irq_en_q <= avs_writedata[BIT_BUF_IRQ_EN];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         baud_div_q <= RST_BAUD_DIV;                                // RULE24
      end else if (wr_lane0 && wsel == UTX_SEL_BAUD) begin
         baud_div_q <= avs_writedata[DIV_W-1:0];                    // RULE2
      end
   end

   // ----------------------------------------------------------------
   // holding buffer and its empty flag
   // ----------------------------------------------------------------
   // the buffer survives a disabled transmitter so data may be queued first
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_q <= RST_HOLD;
      end else if (wr_lane0 && wsel == UTX_SEL_HOLD) begin
         hold_q <= avs_writedata[7:0];
      end
   end

   // a fresh write beats a same-cycle transfer: the new byte still waits
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         hold_full_q <= 1'b0;
      end else if (wr_lane0 && wsel == UTX_SEL_HOLD) begin
         hold_full_q <= 1'b1;                                       // RULE11
      end else if (transfer) begin
         hold_full_q <= 1'b0;                                       // RULE9 RULE10
      end
   end

   // follows the empty flag; the enable only gates the request, never the flag
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= !hold_full_q && irq_en_q;                         // RULE10
      end
   end

   // ----------------------------------------------------------------
   // baud generator
   // ----------------------------------------------------------------
   assign tx_active = port_en_q && tx_en_q && !sync_sel_q;          // RULE7 RULE21
   assign run       = !sleep_req;                                   // RULE6

   // serves the transmitter; a cleared port enable holds it at zero and sleep_req freezes it
   always_ff @(posedge ref_clk) begin
      if (rst || !port_en_q || (wr_lane0 && wsel == UTX_SEL_BAUD)) begin
         div_cnt_q <= '0;                                           // RULE23
         pre_cnt_q <= '0;
      end else if (run) begin                                       // RULE3
         if (div_cnt_q == baud_div_q) begin                         // RULE22
            div_cnt_q <= '0;
            pre_cnt_q <= pre_cnt_q + 6'h01;                         // RULE4
         end else begin
            div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
         end
      end
   end

   assign bit_tick = run && port_en_q && (div_cnt_q == baud_div_q)
                     && (pre_cnt_q == PRESCALE_LAST);

   // ----------------------------------------------------------------
   // transmit sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_d  = state_q;
      transfer = 1'b0;
      if (run) begin
         case (state_q)
            UTX_IDLE: begin
               if (hold_full_q) begin
                  state_d  = UTX_LOADED;                            // RULE16 RULE15
                  transfer = 1'b1;
               end
            end
            UTX_LOADED: begin
               if (bit_tick) begin
                  state_d = UTX_START;                              // RULE14
               end
            end
            UTX_START: begin
               if (bit_tick) begin
                  state_d = UTX_DATA;
               end
            end
            UTX_DATA: begin
               if (bit_tick && bit_cnt_q == DATA_LAST) begin
                  state_d = nine_sel_q ? UTX_NINTH : UTX_STOP;      // RULE18
               end
            end
            UTX_NINTH: begin
               if (bit_tick) begin
                  state_d = UTX_STOP;
               end
            end
            UTX_STOP: begin
               if (bit_tick) begin
                  transfer = hold_full_q;                           // RULE8 RULE9
                  state_d  = hold_full_q ? UTX_START : UTX_IDLE;
               end
            end
            default: state_d = UTX_IDLE;
         endcase
      end
      // applied last so an abort wins over any tick or pending transfer
      if (!tx_active) begin
         state_d  = UTX_IDLE;                                       // RULE17 RULE21
         transfer = 1'b0;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         state_q <= UTX_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         shift_q   <= '0;
         bit_cnt_q <= '0;
      end else if (transfer) begin
         // the ninth bit value is taken with the byte, so a later status write
         // cannot change it; the nine-bit select is still read when the data bits end
         shift_q   <= {ninth_val_q, hold_q};                        // RULE19
         bit_cnt_q <= '0;
      end else if (bit_tick && state_q == UTX_DATA) begin
         shift_q   <= {1'b0, shift_q[8:1]};                         // RULE25
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end

   // ----------------------------------------------------------------
   // line driver
   // ----------------------------------------------------------------
   // the shifter moves on the same tick that launches the next bit, so the
   // bit about to leave sits one place up; the ninth bit follows bit seven
   // down the same path, leaves from position one and is then held from position zero
   always_comb begin
      if (state_q == UTX_DATA && bit_tick) begin
         data_bit = shift_q[1];
      end else begin
         data_bit = shift_q[0];
      end
   end

   always_comb begin
      case (state_d)
         UTX_START: line_d = 1'b0;                                  // RULE26 RULE1
         UTX_DATA:  line_d = data_bit;                              // RULE25
         UTX_NINTH: line_d = data_bit;                              // RULE25 RULE18
         default:   line_d = 1'b1;                                  // RULE26
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         tx_line_q <= 1'b1;
         oe_q      <= 1'b0;
      end else begin
         tx_line_q <= line_d;
         oe_q      <= tx_active;                                    // RULE17
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign tx_pin_o        = tx_line_q;
   assign tx_pin_oe       = oe_q;
   assign tx_irq_req      = irq_q;

endmodule : utx_async_tx

`default_nettype wire

// file: sim/utx_async_tx_checker.sv
// Purpose: port assertions for utx_async_tx
// Assumes: one clock, rst synchronous active high
// Notes:   bound into every utx_async_tx instance
`timescale 1ns/1ps
`default_nettype none

module utx_async_tx_checker
   import utx_pkg::*;
#(
   parameter int DIV_W = 8
) (
   input wire logic              ref_clk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic [31:0]       avs_writedata,
   input wire logic [3:0]        avs_byteenable,
   input wire logic [31:0]       avs_readdata,
   input wire logic              avs_waitrequest,
   input wire logic              sleep_req,
   input wire logic              tx_pin_o,
   input wire logic              tx_pin_oe,
   input wire logic              tx_irq_req
);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   logic [15:0] low_q;

   // a low run is whole bit periods; frozen cycles in sleep do not count
   always_ff @(posedge ref_clk) begin
      if (rst || !tx_pin_oe || tx_pin_o)
         low_q <= 16'h0000;
      else if (!sleep_req)
         low_q <= low_q + 16'h0001;
   end

   chk_wait_answer:
      assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("request not answered");
   chk_wait_single:
      assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   chk_rdata_hold:
      assert property ($changed(avs_readdata) |-> avs_read && !avs_waitrequest)
      else $error("read data moved outside a read");
   chk_rdata_unmapped:
      assert property (avs_read && !avs_waitrequest && avs_address == 5'h14
                       |-> avs_readdata == RDATA_UNMAPPED)
      else $error("unmapped read not zero");
   chk_bit_length:
      assert property ($rose(tx_pin_o) && tx_pin_oe |-> low_q[5:0] == 6'h00 && low_q != 16'h0)
      else $error("low run not whole bit periods");
   chk_start_high:
      assert property ($rose(tx_pin_oe) |-> tx_pin_o)
      else $error("line not at mark when driven");
   chk_sleep_hold:
      assert property ($past(sleep_req) |-> $stable(tx_pin_o))
      else $error("line moved during sleep");
   chk_oe_by_write:
      assert property ($changed(tx_pin_oe) |-> $past(avs_write) || $past(avs_write, 2))
      else $error("drive enable moved without a write");
endmodule : utx_async_tx_checker

bind utx_async_tx utx_async_tx_checker #(.DIV_W(DIV_W)) u_chk (
   .ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sleep_req(sleep_req),
   .tx_pin_o(tx_pin_o), .tx_pin_oe(tx_pin_oe), .tx_irq_req(tx_irq_req)
);

`default_nettype wire

// file: sim/utx_line_peer.sv
// Purpose: remote serial peer that decodes frames from the line
// Assumes: line idles high through a pull-up
// Notes:   samples each bit in its middle at the agreed rate
`timescale 1ns/1ps
`default_nettype none

module utx_line_peer (
   input  wire logic       ref_clk,
   input  wire logic       line,
   input  wire logic       nine,
   input  wire logic [7:0] div,
   output var  logic [8:0] rx_word,
   output var  logic [7:0] rx_count,
   output var  logic       stop_bad
);
   // ----------------------------------------------------------------
   // receiver
   // ----------------------------------------------------------------
   int         per;
   int         i;
   logic [8:0] w;

   initial begin
      rx_word  = 9'h000;
      rx_count = 8'h00;
      stop_bad = 1'b0;
   end

   // knows only the agreed rate, not the sender's baud phase
   always begin
      @(negedge line);
      per = 64 * (int'(div) + 1);
      repeat (per / 2) @(posedge ref_clk);
      if (line === 1'b0) begin
         w = 9'h000;
         for (i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (per) @(posedge ref_clk);
            w[i] = line;
         end
         repeat (per) @(posedge ref_clk);
         stop_bad = (line !== 1'b1);
         rx_word  = w;
         rx_count = rx_count + 8'h01;
      end
   end
endmodule : utx_line_peer

`default_nettype wire

// file: sim/utx_async_tx_tb_top.sv
// Purpose: self-checking bench for utx_async_tx
// Assumes: pull-up on the serial line, peer decodes it
// Notes:   one task per scenario
`timescale 1ns/1ps
`default_nettype none

module utx_async_tx_tb_top;
   import utx_pkg::*;
   // ----------------------------------------------------------------
   // harness
   // ----------------------------------------------------------------
   logic              ref_clk        = 1'b0;
   logic              rst            = 1'b1;
   logic [ADDR_W-1:0] avs_address    = 5'h00;
   logic              avs_read       = 1'b0;
   logic              avs_write      = 1'b0;
   logic [31:0]       avs_writedata  = 32'h0;
   logic [3:0]        avs_byteenable = 4'h1;
   logic              sleep_req      = 1'b0;
   logic              nine           = 1'b0;
   logic [7:0]        div            = 8'h00;
   logic [31:0]       avs_readdata;
   logic              avs_waitrequest;
   logic              tx_pin_o;
   logic              tx_pin_oe;
   logic              tx_irq_req;
   logic              line;
   logic [8:0]        rx_word;
   logic [7:0]        rx_count;
   logic [7:0]        base;
   logic              stop_bad;
   logic [31:0]       q;
   int                n_mismatch     = 0;
   int                n_compared     = 0;

   always #2 ref_clk = ~ref_clk;
   // released pin is pulled up to the marking level
   assign line = tx_pin_oe ? tx_pin_o : 1'b1;

   utx_async_tx dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sleep_req(sleep_req), .tx_pin_o(tx_pin_o),
      .tx_pin_oe(tx_pin_oe), .tx_irq_req(tx_irq_req));
   utx_line_peer peer (.ref_clk(ref_clk), .line(line), .nine(nine), .div(div),
      .rx_word(rx_word), .rx_count(rx_count), .stop_bad(stop_bad));

   task automatic complete_run;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : complete_run

   task automatic hang(input int k, input int lim);
      if (k >= lim) begin
         $display("BAD %0t wait ran out", $time);
         n_mismatch++;
         complete_run();
      end
   endtask : hang

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
      int k;
      @(posedge ref_clk);
      avs_address   <= a;
      avs_write     <= wr;
      avs_read      <= !wr;
      avs_writedata <= {24'h0, d};
      k = 0;
      do begin
         @(posedge ref_clk);
         k++;
      end while (avs_waitrequest !== 1'b0 && k < 64);
      q = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      hang(k, 64);
   endtask : bus

   task automatic rdc(input logic [4:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask : rdc

   // the extra wait lets the stop bit finish: half a stop plus margin
   task automatic wait_rx(input logic [7:0] n, input logic [8:0] w);
      int k;
      for (k = 0; k < 4000 && rx_count !== n; k++)
         @(posedge ref_clk);
      hang(k, 4000);
      chk({23'h0, rx_word}, {23'h0, w});
      chk({31'h0, stop_bad}, 32'h0);
      repeat (40 * (int'(div) + 1)) @(posedge ref_clk);
   endtask : wait_rx

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic sc_reset;
      rdc(OFS_BAUD_DIV, 8'h00);
      rdc(OFS_TX_STAT_CTRL, 8'h02);
      rdc(OFS_TX_FLAGS, 8'h01);
      bus(1'b1, 5'h14, 8'hff);
      rdc(5'h14, 8'h00);
   endtask : sc_reset

   task automatic sc_frame(input logic [7:0] dv, input logic n9, input logic b9,
                           input logic [7:0] d);
      int k;
      bus(1'b1, OFS_TX_STAT_CTRL, 8'h00);
      bus(1'b1, OFS_BAUD_DIV, dv);
      div  = dv;
      nine = n9;
      bus(1'b1, OFS_PORT_CTRL, 8'h80);
      bus(1'b1, OFS_TX_STAT_CTRL, {1'b0, n9, 5'h00, b9});
      bus(1'b1, OFS_TX_HOLD, d);
      base = rx_count;
      bus(1'b1, OFS_TX_STAT_CTRL, {1'b0, n9, 1'b1, 4'h0, b9});
      // the divisor write restarted the timer, so a start bit is due within one bit time
      for (k = 0; k < 64 * (int'(dv) + 1) && line !== 1'b0; k++)
         @(posedge ref_clk);
      chk({31'h0, line}, 32'h0);
      wait_rx(base + 8'h01, {n9 & b9, d});
   endtask : sc_frame

   task automatic sc_b2b;
      bus(1'b1, OFS_TX_FLAGS, 8'h02);
      base = rx_count;
      bus(1'b1, OFS_TX_HOLD, 8'h11);
      rdc(OFS_TX_FLAGS, 8'h03);
      chk({31'h0, tx_irq_req}, 32'h1);
      rdc(OFS_TX_STAT_CTRL, 8'h20);
      bus(1'b1, OFS_TX_HOLD, 8'h22);
      rdc(OFS_TX_FLAGS, 8'h02);
      wait_rx(base + 8'h01, 9'h011);
      rdc(OFS_TX_FLAGS, 8'h03);
      bus(1'b1, OFS_TX_FLAGS, 8'h00);
      rdc(OFS_TX_FLAGS, 8'h01);
      chk({31'h0, tx_irq_req}, 32'h0);
      wait_rx(base + 8'h02, 9'h022);
   endtask : sc_b2b

   task automatic sc_abort;
      int k;
      bus(1'b1, OFS_TX_HOLD, 8'h5a);
      for (k = 0; k < 300 && line !== 1'b0; k++)
         @(posedge ref_clk);
      hang(k, 300);
      repeat (100) @(posedge ref_clk);
      bus(1'b1, OFS_TX_STAT_CTRL, 8'h00);
      rdc(OFS_TX_STAT_CTRL, 8'h02);
      chk({31'h0, tx_pin_oe}, 32'h0);
      repeat (800) @(posedge ref_clk);
      bus(1'b1, OFS_TX_STAT_CTRL, 8'h30);
      bus(1'b1, OFS_TX_HOLD, 8'hc3);
      rdc(OFS_TX_FLAGS, 8'h00);
      chk({31'h0, tx_pin_oe}, 32'h0);
      base = rx_count;
      bus(1'b1, OFS_TX_STAT_CTRL, 8'h20);
      wait_rx(base + 8'h01, 9'h0c3);
   endtask : sc_abort

   task automatic sc_sleep;
      int   k;
      logic moved;
      moved = 1'b0;
      base  = rx_count;
      sleep_req <= 1'b1;
      bus(1'b1, OFS_TX_HOLD, 8'h69);
      for (k = 0; k < 300; k++) begin
         @(posedge ref_clk);
         moved = moved | (line !== 1'b1);
      end
      chk({31'h0, moved}, 32'h0);
      sleep_req <= 1'b0;
      for (k = 0; k < 300 && line !== 1'b0; k++)
         @(posedge ref_clk);
      hang(k, 300);
      // freeze across the end of the start bit, shorter than half a bit so
      // the peer still samples every bit inside its period
      repeat (48) @(posedge ref_clk);
      sleep_req <= 1'b1;
      repeat (20) @(posedge ref_clk);
      chk({31'h0, line}, 32'h0);
      sleep_req <= 1'b0;
      wait_rx(base + 8'h01, 9'h069);
   endtask : sc_sleep

   initial begin
      repeat (12) @(posedge ref_clk);
      rst <= 1'b0;
      sc_reset();
      sc_frame(8'h00, 1'b0, 1'b0, 8'ha5);
      sc_frame(8'h01, 1'b1, 1'b1, 8'h3c);
      sc_frame(8'h00, 1'b0, 1'b0, 8'h0f);
      sc_b2b();
      sc_abort();
      sc_sleep();
      complete_run();
   end

   initial begin
      repeat (100000) @(posedge ref_clk);
      hang(1, 1);
   end
endmodule : utx_async_tx_tb_top

`default_nettype wire
